// file: logic/tap_port.sv
/*
  Test access port with its user data path and the word FIFO behind it.
  Assumes the test controller drives TCK, TMS, TDI and test reset; the
  system side reads words with valid and ready on i_clk.
*/
`timescale 1ns/1ps
`include "tap_params.svh"

module tap_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  wire           push = i_in_valid && o_in_ready;
  wire           pop  = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready  = (cnt_r != (AW+1)'(D));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= bump(wr_r);
      if (pop) rd_r <= bump(rd_r);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (push && !pop) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo count did not rise on push");

  fifo_drop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pop && !push) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("fifo count did not fall on pop");

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cnt_r <= (AW+1)'(D))
    else $error("fifo count above depth");
endmodule

module tap_port import tap_pkg::*; #(
  parameter int             FIFO_D = `TAP_FIFO_D,
  parameter logic [31:0]    ID_VAL = 32'h0000_0001  // Arbitrary identity value
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_tck,
  input  wire logic                   i_trst_n,
  input  wire logic                   i_tms,
  input  wire logic                   i_tdi,
  output logic                        o_tdo,
  output logic                        o_tdo_oe,
  output logic                        o_valid,
  input  wire logic                   i_ready,
  output logic [`TAP_USER_W-1:0]      o_data
);
  tap_state_t              st_r;
  tap_state_t              st_nxt;
  logic [`TAP_IR_W-1:0]    ir_r;
  logic [`TAP_IR_W-1:0]    irs_r;
  logic [`TAP_ID_W-1:0]    id_r;
  logic [`TAP_USER_W-1:0]  usr_r;
  logic                    byp_r;
  xfer_t                   xf_r;
  logic                    ack_s1_r;
  logic                    ack_s2_r;
  logic                    tdo_r;
  logic                    oe_r;
  logic                    req_s1_r;
  logic                    req_s2_r;
  logic                    ack_r;
  logic                    fifo_rdy;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    case (s)
      ST_TLR:  tap_next = m ? ST_TLR  : ST_RTI;
      ST_RTI:  tap_next = m ? ST_SDRS : ST_RTI;
      ST_SDRS: tap_next = m ? ST_SIRS : ST_CDR;
      ST_CDR:  tap_next = m ? ST_E1DR : ST_SDR;
      ST_SDR:  tap_next = m ? ST_E1DR : ST_SDR;
      ST_E1DR: tap_next = m ? ST_UDR  : ST_PDR;
      ST_PDR:  tap_next = m ? ST_E2DR : ST_PDR;
      ST_E2DR: tap_next = m ? ST_UDR  : ST_SDR;
      ST_UDR:  tap_next = m ? ST_SDRS : ST_RTI;
      ST_SIRS: tap_next = m ? ST_TLR  : ST_CIR;
      ST_CIR:  tap_next = m ? ST_E1IR : ST_SIR;
      ST_SIR:  tap_next = m ? ST_E1IR : ST_SIR;
      ST_E1IR: tap_next = m ? ST_UIR  : ST_PIR;
      ST_PIR:  tap_next = m ? ST_E2IR : ST_PIR;
      ST_E2IR: tap_next = m ? ST_UIR  : ST_SIR;
      ST_UIR:  tap_next = m ? ST_SDRS : ST_RTI;
      default: tap_next = ST_TLR;
    endcase
  endfunction

  // Link side: every flop is on i_tck only, so a stopped clock freezes all
  assign st_nxt = tap_next(st_r, i_tms);  // RQ2 RQ7
  wire sel_id   = (ir_r == `TAP_IR_IDCODE);
  wire sel_usr  = (ir_r == `TAP_IR_USER);
  wire busy     = (xf_r.tgl != ack_s2_r);
  wire shift_dr = (st_r == ST_SDR);
  wire shift_ir = (st_r == ST_SIR);
  wire dr_out   = sel_id ? id_r[0] : (sel_usr ? usr_r[0] : byp_r);
  wire tdo_mux  = shift_ir ? irs_r[0] : dr_out;

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      st_r <= ST_TLR;  // RQ1
    end else begin
      st_r <= st_nxt;  // RQ3 RQ6
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      irs_r <= '0;
      ir_r  <= `TAP_IR_IDCODE;  // RQ1
    end else begin
      if (st_r == ST_CIR) irs_r <= `TAP_IR_CAPT;
      if (shift_ir) irs_r <= {i_tdi, irs_r[`TAP_IR_W-1:1]};  // RQ4 RQ7
      if (st_r == ST_UIR) ir_r <= irs_r;
      if (st_r == ST_TLR) ir_r <= `TAP_IR_IDCODE;
    end
  end

  // Status on capture tells the tester whether a word is still in flight
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      id_r  <= '0;
      usr_r <= '0;
      byp_r <= 1'b0;
    end else begin
      if (st_r == ST_CDR) begin
        id_r  <= ID_VAL;
        usr_r <= {{(`TAP_USER_W-1){1'b0}}, busy};
        byp_r <= 1'b0;
      end else if (shift_dr) begin
        if (sel_id) id_r <= {i_tdi, id_r[`TAP_ID_W-1:1]};  // RQ4
        if (sel_usr) usr_r <= {i_tdi, usr_r[`TAP_USER_W-1:1]};  // RQ4
        byp_r <= i_tdi;
      end
    end
  end

  // An update while busy is dropped rather than corrupting the held word
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      xf_r <= '0;
    end else if (st_r == ST_UDR && sel_usr && !busy) begin
      xf_r.data <= usr_r;
      xf_r.tgl  <= ~xf_r.tgl;
    end
  end

  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      tdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      tdo_r <= tdo_mux;  // RQ5
      oe_r  <= shift_ir || shift_dr;  // RQ5
    end
  end

  assign o_tdo    = tdo_r;
  assign o_tdo_oe = oe_r;

  // System side: toggle handshake, data stays still until acknowledged
  wire pending = (req_s2_r != ack_r);
  wire push    = pending && fifo_rdy;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r    <= 1'b0;
    end else begin
      req_s1_r <= xf_r.tgl;
      req_s2_r <= req_s1_r;
      if (push) ack_r <= req_s2_r;
    end
  end

  tap_fifo #(
    .W (`TAP_USER_W),
    .D (FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (pending),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (xf_r.data),
    .o_out_valid (o_valid),
    .i_out_ready (i_ready),
    .o_out_data  (o_data)
  );

  trst_hold_a: assert property (@(posedge i_tck) disable iff (1'b0)  // RQ1
    !i_trst_n |-> st_r == ST_TLR)
    else $error("controller not in reset while test reset low");

  tms_five_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ2
    i_tms [*5] |=> st_r == ST_TLR)
    else $error("five high TMS did not reach reset state");

  tms_step_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ3
    (st_r == ST_RTI && !i_tms) |=> st_r == ST_RTI)
    else $error("idle left with TMS low");

  tdi_user_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ4
    (shift_dr && sel_usr) |=> usr_r[`TAP_USER_W-1] == $past(i_tdi))
    else $error("TDI not captured into user register");

  tdo_launch_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ5
    ($past(shift_ir) && shift_ir) |-> o_tdo == irs_r[0] && o_tdo_oe)
    else $error("TDO not launched from instruction shift");

  ir_update_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ7
    (st_r == ST_UIR) |=> ir_r == $past(irs_r))
    else $error("instruction not updated");

  id_capture_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ7
    (st_r == ST_CDR && sel_id) |=> id_r == ID_VAL)
    else $error("identity not captured");

  bypass_bit_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ7
    (shift_dr && !sel_id && !sel_usr) |=> byp_r == $past(i_tdi) ##0 dr_out == byp_r)
    else $error("bypass path wrong");

  trst_ir_a: assert property (@(posedge i_tck) disable iff (1'b0)  // RQ1
    !i_trst_n |-> ir_r == `TAP_IR_IDCODE && !o_tdo_oe)
    else $error("instruction or TDO enable not held by test reset");

  tlr_exit_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ2
    (st_r == ST_TLR && !i_tms) |=> st_r == ST_RTI)
    else $error("reset state not left with TMS low");

  ir_select_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ2
    (st_r == ST_SDRS && i_tms) |=> st_r == ST_SIRS)
    else $error("TMS high did not select instruction path");

  shift_hold_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ3
    (shift_dr && !i_tms) |=> shift_dr)
    else $error("data shift left with TMS low");

  tdi_ir_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ4
    shift_ir |=> irs_r[`TAP_IR_W-1] == $past(i_tdi))
    else $error("TDI not captured into instruction shifter");

  tdo_dr_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ5
    (shift_dr && $past(shift_dr)) |-> o_tdo == dr_out && o_tdo_oe)
    else $error("TDO not launched from data shift");

  tdo_off_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ5
    !(shift_ir || shift_dr) |-> !o_tdo_oe)
    else $error("TDO driven outside shift states");

  upd_take_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ7
    (st_r == ST_UDR && sel_usr && !busy) |=> xf_r.tgl != $past(xf_r.tgl) && xf_r.data == $past(usr_r))
    else $error("user word not handed over on update");

  upd_drop_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)  // RQ7
    (st_r == ST_UDR && sel_usr && busy) |=> xf_r == $past(xf_r))
    else $error("held word disturbed by update while busy");

  // Word must stand still for the whole time the other side may sample it
  cdc_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)  // RQ7
    pending |-> $stable(xf_r.data))
    else $error("crossing word changed while pending");

  ack_close_a: assert property (@(posedge i_clk) disable iff (!i_resetn)  // RQ7
    push |=> !pending)
    else $error("handshake still pending after push");
endmodule

// file: logic/tap_params.svh
/*
  Constants of the serial test access port: instruction codes, register
  lengths and reset values. Assumes inclusion by the package and the port.
*/
// Function
// RQ1 - Test reset low holds controller in reset
// RQ2 - TMS high steers the controller states
// RQ3 - TMS sampled on each rising TCK
// RQ4 - TDI captured on each rising TCK
// RQ5 - TDO changes on each falling TCK
// RQ6 - Stopped TCK keeps all state unchanged
// RQ7 - Sixteen-state controller with IR/DR paths
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

`define TAP_IR_W      4
`define TAP_IR_BYPASS 4'hF
`define TAP_IR_IDCODE 4'h1
`define TAP_IR_USER   4'h2
`define TAP_IR_CAPT   4'h1
`define TAP_ID_W      32
`define TAP_USER_W    8
`define TAP_FIFO_D    32

`endif

// file: logic/tap_pkg.sv
/*
  Types of the serial test access port: controller states and the word
  handed from the test clock domain to the system clock domain.
*/
`include "tap_params.svh"
package tap_pkg;
  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001,
    ST_RTI  = 16'h0002,
    ST_SDRS = 16'h0004,
    ST_CDR  = 16'h0008,
    ST_SDR  = 16'h0010,
    ST_E1DR = 16'h0020,
    ST_PDR  = 16'h0040,
    ST_E2DR = 16'h0080,
    ST_UDR  = 16'h0100,
    ST_SIRS = 16'h0200,
    ST_CIR  = 16'h0400,
    ST_SIR  = 16'h0800,
    ST_E1IR = 16'h1000,
    ST_PIR  = 16'h2000,
    ST_E2IR = 16'h4000,
    ST_UIR  = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic                   tgl;
    logic [`TAP_USER_W-1:0] data;
  } xfer_t;
endpackage

// file: tb/jtag_ctl.sv
/*
  Behavioural boundary-scan test controller driving the serial test link.
  Assumes the bench calls its tasks one at a time; TCK stands low between
  frames; TDI rests high as its pull-up would leave it, and TMS too after scan but low after idle or to_idle.
*/
`timescale 1ns/1ps

module jtag_ctl (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // Inputs change only while TCK is low, so they stand around the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #80 o_tck = 1'b1;
    tdo = i_tdo;
    #80 o_tck = 1'b0;
  endtask

  task automatic idle(input int n);
    logic b;
    repeat (n) step(1'b0, 1'b1, b);
  endtask

  task automatic to_idle();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask

  // From Run-Test/Idle through one shift path and back to Run-Test/Idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    step(1'b1, 1'b1, b);
    if (ir) begin
      step(1'b1, 1'b1, b);
    end
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    o_tms = 1'b1;
    o_tdi = 1'b1;
  endtask
endmodule

// file: tb/testbench.sv
/*
  Bench for the test access port: capture, bypass, reset, user words,
  full FIFO and dropped updates.
  Assumes jtag_ctl drives the link and the FIFO is two words deep.
*/
`timescale 1ns/1ps

module testbench;
  logic        i_clk;
  logic        i_resetn;
  logic        i_trst_n;
  logic        i_ready;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        o_tdo;
  logic        o_tdo_oe;
  logic        o_valid;
  logic [7:0]  o_data;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // Released TDO floats, so a late enable shows up as a mismatch
  wire         tdo_w = o_tdo_oe ? o_tdo : 1'bz;

  // Identity value is arbitrary
  tap_port #(.FIFO_D(2), .ID_VAL(32'h1234_5679)) dut_u (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_tck    (tck),
    .i_trst_n (i_trst_n),
    .i_tms    (tms),
    .i_tdi    (tdi),
    .o_tdo    (o_tdo),
    .o_tdo_oe (o_tdo_oe),
    .o_valid  (o_valid),
    .i_ready  (i_ready),
    .o_data   (o_data)
  );

  jtag_ctl ctl_u (
    .o_tck (tck),
    .o_tms (tms),
    .o_tdi (tdi),
    .i_tdo (tdo_w)
  );

  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic pop(input logic [7:0] exp);
    int k;
    k = 0;
    @(negedge i_clk);
    while (o_valid !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    if (o_valid !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    chk("fifo_word", {24'h0, exp}, {24'h0, o_data});
    i_ready = 1'b1;
    @(negedge i_clk);
    i_ready = 1'b0;
  endtask

  task automatic t_scan();
    ctl_u.to_idle();
    ctl_u.scan(1'b1, 4, 32'hF, d);
    chk("ir_capture", 32'h1, d);
    ctl_u.scan(1'b0, 8, 32'hA5, d);
    chk("bypass", 32'h4A, d);
  endtask

  // Test reset holds the controller while TCK runs, then restores identity
  task automatic t_trst();
    i_trst_n = 1'b0;
    #50;
    ctl_u.idle(2);
    #50 i_trst_n = 1'b1;
    ctl_u.idle(1);
    ctl_u.scan(1'b0, 32, 32'h0, d);
    chk("idcode", 32'h1234_5679, d);
  endtask

  task automatic t_user();
    logic t0;
    ctl_u.scan(1'b1, 4, 32'h2, d);
    @(negedge i_clk);
    t0 = o_tdo;
    repeat (20) @(negedge i_clk);
    chk("tdo_hold", {31'h0, t0}, {31'h0, o_tdo});
    ctl_u.scan(1'b0, 8, 32'h3C, d);
    ctl_u.idle(6);
    ctl_u.scan(1'b0, 8, 32'hC3, d);
    ctl_u.idle(6);
    repeat (10) @(negedge i_clk);
    pop(8'h3C);
    pop(8'hC3);
    @(negedge i_clk);
    chk("fifo_empty", 32'h0, {31'h0, o_valid});
  endtask

  // Two-word FIFO fills; third word stalls, fourth is dropped while busy
  task automatic t_full();
    ctl_u.scan(1'b0, 8, 32'h11, d);
    chk("busy_clear", 32'h0, d);
    ctl_u.idle(6);
    ctl_u.scan(1'b0, 8, 32'h22, d);
    ctl_u.idle(6);
    ctl_u.scan(1'b0, 8, 32'h33, d);
    ctl_u.idle(6);
    ctl_u.scan(1'b0, 8, 32'h44, d);
    chk("busy_set", 32'h1, d);
    pop(8'h11);
    pop(8'h22);
    pop(8'h33);
    repeat (10) @(negedge i_clk);
    chk("drop_empty", 32'h0, {31'h0, o_valid});
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Resets start high so their fall is a real edge after time zero
  initial begin
    i_resetn = 1'b1;
    i_trst_n = 1'b1;
    i_ready = 1'b0;
    #10;
    i_resetn = 1'b0;
    i_trst_n = 1'b0;
    repeat (5) @(negedge i_clk);
    i_resetn = 1'b1;
    i_trst_n = 1'b1;
    #37;
    t_scan();
    t_trst();
    t_user();
    t_full();
    give_verdict();
  end
endmodule
